// ### region_prot_pkg.sv
// Package: constants for the region protection access registers
package region_prot_pkg;

  // ==========================================================================
  // Field layout of the access control word
  // ==========================================================================
  localparam int unsigned PERM_LSB     = 2;
  localparam int unsigned PERM_W       = 3;
  localparam int unsigned CACHE_BIT    = 5;
  localparam int unsigned RD_BIT       = 0;
  localparam int unsigned WR_BIT       = 1;
  localparam int unsigned SIZE_LSB     = 6;
  localparam int unsigned SIZE_W       = 25;
  localparam logic [31:0] ACC_RESET    = 32'h0000_0000;

  // ==========================================================================
  // Base word layout
  // ==========================================================================
  localparam int unsigned DSEL_BIT     = 0;
  localparam int unsigned INDEX_LSB    = 1;
  localparam int unsigned BASE_LSB     = 6;
  localparam logic [31:0] BASE_RESET   = 32'h0000_0000;

  // ==========================================================================
  // Size encodings
  // ==========================================================================
  localparam logic [24:0] MASK_64B     = 25'h1ff_ffff;
  localparam logic [24:0] MASK_2GB     = 25'h000_0000;

  // ==========================================================================
  // Permission codes
  // ==========================================================================
  localparam logic [2:0] PERM_NONE     = 3'h0;
  localparam logic [2:0] PERM_S_R      = 3'h1;
  localparam logic [2:0] PERM_SU_R     = 3'h2;
  localparam logic [2:0] PERM_S_RW     = 3'h4;
  localparam logic [2:0] PERM_S_RW_U_R = 3'h5;
  localparam logic [2:0] PERM_SU_RW    = 3'h6;

  // Data permission decode: returns allowed for mode and direction
  function automatic logic data_allowed(input logic [2:0] perm,
                                        input logic       user,
                                        input logic       write);
    logic r;
    r = 1'b0;
    case (perm)
      PERM_S_R:      r = !user && !write;
      PERM_SU_R:     r = !write;
      PERM_S_RW:     r = !user;
      PERM_S_RW_U_R: r = !user || !write;
      PERM_SU_RW:    r = 1'b1;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction

  // Instruction permission decode
  function automatic logic inst_allowed(input logic [2:0] perm,
                                        input logic       user);
    logic r;
    r = 1'b0;
    case (perm)
      3'h1:    r = !user;
      3'h2:    r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ### region_table.sv
// Region storage: one array each of base, size, cache and permission words
`timescale 1ns/1ps
module region_table
  import region_prot_pkg::*;
#(
  parameter int NUM_REGIONS = 8,
  parameter int IDX_W       = 3,
  parameter int SZW         = 25
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             we,
  input  wire logic [IDX_W-1:0] waddr,
  input  wire logic [SZW-1:0]   wbase,
  input  wire logic [SZW-1:0]   wsize,
  input  wire logic             wcache,
  input  wire logic [2:0]       wperm,
  input  wire logic [IDX_W-1:0] raddr,
  output logic      [SZW-1:0]   rbase,
  output logic      [SZW-1:0]   rsize,
  output logic                  rcache,
  output logic      [2:0]       rperm,
  output logic [NUM_REGIONS-1:0][SZW-1:0] all_base,
  output logic [NUM_REGIONS-1:0][SZW-1:0] all_size,
  output logic [NUM_REGIONS-1:0]          all_cache,
  output logic [NUM_REGIONS-1:0][2:0]     all_perm
);

  // ==========================================================================
  // Storage; cleared at reset so an unloaded region holds permission code 0 and grants nothing
  // ==========================================================================
  logic [NUM_REGIONS-1:0][SZW-1:0] base_q;
  logic [NUM_REGIONS-1:0][SZW-1:0] size_q;
  logic [NUM_REGIONS-1:0]          cache_q;
  logic [NUM_REGIONS-1:0][2:0]     perm_q;

  // Region store from the write strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      base_q  <= '0;
      size_q  <= '0;
      cache_q <= '0;
      perm_q  <= '0;
    end else if (we) begin
      base_q[waddr]  <= wbase;
      size_q[waddr]  <= wsize;
      cache_q[waddr] <= wcache;
      perm_q[waddr]  <= wperm;
    end
  end

  // Read port and full view for the matcher
  assign rbase     = base_q[raddr];
  assign rsize     = size_q[raddr];
  assign rcache    = cache_q[raddr];
  assign rperm     = perm_q[raddr];
  assign all_base  = base_q;
  assign all_size  = size_q;
  assign all_cache = cache_q;
  assign all_perm  = perm_q;

endmodule // region_table

// ### region_protection_access_regs.sv
// Region protection unit: access and base registers, storage, checking
//
// Summary of operation
// - Mask variant: size mask field, resets zero
// - Mask or limit field, fixed at build
// - Limit variant: bound is first address above
// - Cacheable flag, data regions only, reset zero
// - Permission code field, resets zero
// - Instruction codes: none, supervisor, both execute
// - Data codes decode supervisor/user read/write
// - Read strobe fetches selected region back
// - Write strobe stores registers into region
// - Mask is all-ones shifted by log2 size
// - Overlap resolved by highest priority match
// - Unit disabled after reset
// - Base field is start over granule size
// - Region number sets priority, lower first
// - Data-select picks data or instruction region
// - Exception on disallowed or unmatched access
`timescale 1ns/1ps
module region_protection_access_regs
  import region_prot_pkg::*;
#(
  parameter bit USE_LIMIT   = 1'b0,
  parameter int NUM_DREG    = 8,
  parameter int NUM_IREG    = 8,
  parameter int IDX_W       = 5,
  parameter int GRAN_LOG2   = 6
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        base_wr,
  input  wire logic [31:0] base_wdata,
  input  wire logic        acc_wr,
  input  wire logic [31:0] acc_wdata,
  output logic      [31:0] base_rdata,
  output logic      [31:0] acc_rdata,
  input  wire logic        unit_enable,
  input  wire logic        inst_valid,
  input  wire logic [31:0] inst_addr,
  input  wire logic        inst_user,
  output logic             inst_fault,
  input  wire logic        data_valid,
  input  wire logic [31:0] data_addr,
  input  wire logic        data_user,
  input  wire logic        data_write,
  output logic             data_fault,
  output logic             data_cacheable,
  output logic             unit_active
);

  localparam int SZW   = 32 - GRAN_LOG2;
  localparam int IW_D  = $clog2(NUM_DREG);
  localparam int IW_I  = $clog2(NUM_IREG);

  // ==========================================================================
  // Software-visible registers
  // ==========================================================================
  logic [SZW-1:0]   base_q;
  logic [IDX_W-1:0] index_q;
  logic             dsel_q;
  logic [SZW-1:0]   size_q;
  logic             cache_q;
  logic [2:0]       perm_q;
  logic             active_q;

  logic             fetch;
  logic             store;
  logic [SZW-1:0]   d_rbase, d_rsize, i_rbase, i_rsize;
  logic             d_rcache, i_rcache;
  logic [2:0]       d_rperm, i_rperm;

  // Strobes are write-only pulses; both together is undefined, fetch wins
  assign fetch = acc_wr && acc_wdata[RD_BIT];
  assign store = acc_wr && acc_wdata[WR_BIT] && !fetch;

  // Enable state; cleared by reset so no check happens until software sets it
  always_ff @(posedge clk) begin
    if (srst) active_q <= 1'b0;
    else      active_q <= unit_enable;
  end
  assign unit_active = active_q;

  // Base register: plain write, or reload on fetch
  always_ff @(posedge clk) begin
    if (srst) begin
      base_q  <= '0;
      index_q <= '0;
      dsel_q  <= 1'b0;
    end else if (base_wr) begin
      base_q  <= base_wdata[31 -: SZW];
      index_q <= base_wdata[INDEX_LSB +: IDX_W];
      dsel_q  <= base_wdata[DSEL_BIT];
    end else if (fetch) begin
      base_q  <= dsel_q ? d_rbase : i_rbase;
    end
  end

  // Access register: size field is mask or limit per build option
  always_ff @(posedge clk) begin
    if (srst) begin
      size_q  <= '0;
      cache_q <= 1'b0;
      perm_q  <= '0;
    end else if (fetch) begin
      size_q  <= dsel_q ? d_rsize : i_rsize;
      cache_q <= dsel_q ? d_rcache : i_rcache;
      perm_q  <= dsel_q ? d_rperm : i_rperm;
    end else if (acc_wr) begin
      size_q  <= acc_wdata[31 -: SZW];
      cache_q <= acc_wdata[CACHE_BIT];
      perm_q  <= acc_wdata[PERM_LSB +: PERM_W];
    end
  end

  // Readback; strobes read as zero, and base field packs at its granule.
  // Built field by field so a full-width index leaves no zero-size pad.
  always_comb begin
    base_rdata                     = '0;
    base_rdata[31 -: SZW]          = base_q;
    base_rdata[INDEX_LSB +: IDX_W] = index_q;
    base_rdata[DSEL_BIT]           = dsel_q;
  end
  assign acc_rdata  = {size_q, cache_q, perm_q, 2'b00};

  // ==========================================================================
  // Region storage, one table per region kind
  // ==========================================================================
  logic [NUM_DREG-1:0][SZW-1:0] d_base, d_size;
  logic [NUM_DREG-1:0]          d_cache;
  logic [NUM_DREG-1:0][2:0]     d_perm;
  logic [NUM_IREG-1:0][SZW-1:0] i_base, i_size;
  logic [NUM_IREG-1:0]          i_cache;
  logic [NUM_IREG-1:0][2:0]     i_perm;

  region_table #(.NUM_REGIONS(NUM_DREG), .IDX_W(IW_D), .SZW(SZW)) u_dtab (
    .clk       (clk),
    .srst      (srst),
    .we        (store && dsel_q),
    .waddr     (index_q[IW_D-1:0]),
    .wbase     (base_q),
    // The storing write carries the new access fields; the register
    // only takes them at the same edge, so read them from the bus
    .wsize     (acc_wdata[31 -: SZW]),
    .wcache    (acc_wdata[CACHE_BIT]),
    .wperm     (acc_wdata[PERM_LSB +: PERM_W]),
    .raddr     (index_q[IW_D-1:0]),
    .rbase     (d_rbase),
    .rsize     (d_rsize),
    .rcache    (d_rcache),
    .rperm     (d_rperm),
    .all_base  (d_base),
    .all_size  (d_size),
    .all_cache (d_cache),
    .all_perm  (d_perm)
  );

  region_table #(.NUM_REGIONS(NUM_IREG), .IDX_W(IW_I), .SZW(SZW)) u_itab (
    .clk       (clk),
    .srst      (srst),
    .we        (store && !dsel_q),
    .waddr     (index_q[IW_I-1:0]),
    .wbase     (base_q),
    .wsize     (acc_wdata[31 -: SZW]),
    .wcache    (1'b0),
    .wperm     (acc_wdata[PERM_LSB +: PERM_W]),
    .raddr     (index_q[IW_I-1:0]),
    .rbase     (i_rbase),
    .rsize     (i_rsize),
    .rcache    (i_rcache),
    .rperm     (i_rperm),
    .all_base  (i_base),
    .all_size  (i_size),
    .all_cache (i_cache),
    .all_perm  (i_perm)
  );

  // ==========================================================================
  // Address checking
  // ==========================================================================
  // Region hit test; granule address compared as mask or as range
  function automatic logic hit(input logic [SZW-1:0] gaddr,
                               input logic [SZW-1:0] rbase,
                               input logic [SZW-1:0] rsize);
    if (USE_LIMIT)
      return (gaddr >= rbase) && (gaddr < rsize);
    else
      return (gaddr & rsize) == rbase;
  endfunction

  logic [SZW-1:0] d_gaddr, i_gaddr;
  logic           d_ok, d_c, i_ok;

  assign d_gaddr = data_addr[31 -: SZW];
  assign i_gaddr = inst_addr[31 -: SZW];

  // Priority search: scan from highest index so region 0 wins overlaps
  always_comb begin
    d_ok = 1'b0;
    d_c  = 1'b0;
    for (int k = NUM_DREG - 1; k >= 0; k--) begin
      if (hit(d_gaddr, d_base[k], d_size[k])) begin
        d_ok = data_allowed(d_perm[k], data_user, data_write);
        d_c  = d_cache[k];
      end
    end
  end

  // Instruction search, same priority order
  always_comb begin
    i_ok = 1'b0;
    for (int k = NUM_IREG - 1; k >= 0; k--) begin
      if (hit(i_gaddr, i_base[k], i_size[k]))
        i_ok = inst_allowed(i_perm[k], inst_user);
    end
  end

  // Registered fault and cacheability; no match means fault when active
  always_ff @(posedge clk) begin
    if (srst) begin
      inst_fault     <= 1'b0;
      data_fault     <= 1'b0;
      data_cacheable <= 1'b0;
    end else begin
      inst_fault     <= active_q && inst_valid && !i_ok;
      data_fault     <= active_q && data_valid && !d_ok;
      data_cacheable <= active_q && data_valid && d_c;
    end
  end

endmodule // region_protection_access_regs

// ### region_prot_chk_sva.sv
// Checker: port timing relations of the region protection unit
`timescale 1ns/1ps
module region_prot_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        base_wr,
  input wire logic [31:0] base_wdata,
  input wire logic        acc_wr,
  input wire logic [31:0] acc_wdata,
  input wire logic [31:0] base_rdata,
  input wire logic [31:0] acc_rdata,
  input wire logic        unit_enable,
  input wire logic        unit_active,
  input wire logic        inst_valid,
  input wire logic        inst_fault,
  input wire logic        data_valid,
  input wire logic        data_fault
);
  // ==========================================================================
  // Assertions, all in the one clock domain
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Checked on the first edge out of reset, when srst has just fallen
  property p_rst; $fell(srst) |-> !unit_active && acc_rdata == 32'h0
    && base_rdata == 32'h0; endproperty
  a_rst: assert property (p_rst)
    else $error("registers not clear after reset");
  property p_act; 1'b1 |=> unit_active == $past(unit_enable); endproperty
  a_act: assert property (p_act)
    else $error("unit active does not follow enable");
  property p_off; !unit_active |=> !inst_fault && !data_fault; endproperty
  a_off: assert property (p_off)
    else $error("fault raised while unit inactive");
  property p_dq; !data_valid |=> !data_fault; endproperty
  a_dq: assert property (p_dq)
    else $error("data fault without an access");
  property p_iq; !inst_valid |=> !inst_fault; endproperty
  a_iq: assert property (p_iq)
    else $error("fetch fault without an access");
  property p_accw; acc_wr && acc_wdata[1:0] == 2'h0 |=>
    acc_rdata == {$past(acc_wdata[31:2]), 2'h0}; endproperty
  a_accw: assert property (p_accw)
    else $error("access word readback wrong");
  property p_basew; base_wr |=>
    base_rdata[30:0] == $past(base_wdata[30:0]); endproperty
  a_basew: assert property (p_basew)
    else $error("base word readback wrong");
  // Without a write the access word must hold its value
  property p_hold; !acc_wr |=> $stable(acc_rdata); endproperty
  a_hold: assert property (p_hold)
    else $error("access word changed without a write");
endmodule // region_prot_chk

// ### core_model.sv
// Processor core model: control writes, enable and memory accesses
`timescale 1ns/1ps
module core_model (
  input  wire logic clk,
  output logic base_wr, acc_wr, unit_enable,
  output logic [31:0] base_wdata, acc_wdata,
  output logic inst_valid, inst_user, data_valid, data_user, data_write,
  output logic [31:0] inst_addr, data_addr
);
  // ==========================================================================
  // Requests launched 1 ns after an edge, released after the taking edge
  // ==========================================================================
  initial begin
    {base_wr, acc_wr, unit_enable, base_wdata, acc_wdata} = '0;
    {inst_valid, inst_user, data_valid, data_user, data_write} = '0;
    {inst_addr, data_addr} = '0;
  end
  // One control write; released words are inverted, not left stale
  task automatic ctl(input logic acc, input logic [31:0] v);
    @(posedge clk) #1;
    {acc_wr, base_wr, acc_wdata, base_wdata} = {acc, !acc, v, v};
    @(posedge clk) #1;
    {acc_wr, base_wr, acc_wdata, base_wdata} = {2'h0, ~v, ~v};
  endtask
  // Regions are power-of-two sized; the caller aligns all but the disabled ones
  task automatic store(input logic d, input logic [4:0] idx,
      input logic [24:0] b, input logic [24:0] m, input logic c,
      input logic [2:0] p);
    ctl(1'b0, {1'b0, b, idx, d});
    ctl(1'b1, {1'b0, m, c, p, 2'h2});
  endtask
  task automatic fetch(input logic d, input logic [4:0] idx);
    ctl(1'b0, {26'h0, idx, d});
    ctl(1'b1, 32'h1);
  endtask
  // Disabled before any reconfiguration, enabled before use
  task automatic en(input logic v);
    @(posedge clk) #1;
    unit_enable = v;
    @(posedge clk) #1;
  endtask
  task automatic acc(input logic i, input logic [31:0] a,
      input logic u, input logic w);
    @(posedge clk) #1;
    {inst_valid, data_valid, inst_addr, data_addr} = {i, !i, a, a};
    {inst_user, data_user, data_write} = {u, u, w};
    @(posedge clk) #1;
    {inst_valid, data_valid, inst_addr, data_addr} = {2'h0, ~a, ~a};
  endtask
endmodule // core_model

// ### tb_region_protection_access_regs.sv
// Testbench for the region protection access registers
`timescale 1ns/1ps
module tb_region_protection_access_regs;
  import region_prot_pkg::*;
  logic clk, srst, base_wr, acc_wr, unit_enable, unit_active;
  logic inst_valid, inst_user, inst_fault, data_valid, data_user;
  logic data_write, data_fault, data_cacheable;
  logic [31:0] base_wdata, acc_wdata, base_rdata, acc_rdata;
  logic [31:0] inst_addr, data_addr, a_word;
  int error_cnt = 0;
  int checked = 0;
  // Allowed masks indexed {user, write}; codes 3 and 7 are unused
  logic [3:0] dtab [8] = '{4'h0, 4'h1, 4'h5, 4'h0, 4'h3, 4'h7, 4'hf, 4'h0};
  logic [1:0] itab [3] = '{2'h0, 2'h1, 2'h3};
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  region_protection_access_regs uut (.clk, .srst, .base_wr, .base_wdata,
    .acc_wr, .acc_wdata, .base_rdata, .acc_rdata, .unit_enable,
    .inst_valid, .inst_addr, .inst_user, .inst_fault, .data_valid,
    .data_addr, .data_user, .data_write, .data_fault, .data_cacheable,
    .unit_active);
  core_model core (.clk, .base_wr, .acc_wr, .unit_enable, .base_wdata,
    .acc_wdata, .inst_valid, .inst_user, .data_valid, .data_user,
    .data_write, .inst_addr, .data_addr);
  // ==========================================================================
  // Comparison and closing report
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard, far beyond the normal run length
  initial begin
    #3000000;
    error_cnt++;
    end_of_test();
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    chk(acc_rdata, 32'h0);
    chk(base_rdata, 32'h0);
    core.acc(1'b0, 32'h1000, 1'b1, 1'b1);
    chk(32'(data_fault), 32'h0);
    a_word = {1'b0, 25'h1ffff00, 1'b1, 3'h5, 2'h0};
    core.ctl(1'b1, a_word);
    chk(acc_rdata, a_word);
    // Low-priority 8 KB region at 0 lets everything; region 0 sits inside
    core.store(1'b1, 5'h1, 25'h0, 25'h1ffff80, 1'b0, 3'h6);
    // Unused regions off: nonzero base, full span; permissive code proves
    // that a disabled region never grants an access
    for (int r = 2; r < 8; r++) begin
      core.store(1'b1, 5'(r), 25'h1, MASK_2GB, 1'b0, 3'h6);
    end
    foreach (codes[k]) begin
      core.en(1'b0);
      core.store(1'b1, 5'h0, 25'h40, MASK_64B, k[0], codes[k]);
      core.fetch(1'b1, 5'h0);
      chk(acc_rdata, {1'b0, MASK_64B, k[0], codes[k], 2'h0});
      chk(base_rdata, {1'b0, 25'h40, 5'h0, 1'b1});
      core.en(1'b1);
      for (int j = 0; j < 4; j++) begin
        core.acc(1'b0, 32'h1000, j[1], j[0]);
        chk(32'(data_fault), 32'(!dtab[codes[k]][j]));
      end
      chk(32'(data_cacheable), 32'(k[0]));
    end
    core.acc(1'b0, 32'h1800, 1'b1, 1'b1);
    chk(32'(data_fault), 32'h0);
    core.acc(1'b0, 32'h2000, 1'b0, 1'b0);
    chk(32'(data_fault), 32'h1);
    for (int p = 0; p < 3; p++) begin
      core.en(1'b0);
      core.store(1'b0, 5'h0, 25'h40, MASK_64B, 1'b0, 3'(p));
      core.en(1'b1);
      for (int u = 0; u < 2; u++) begin
        core.acc(1'b1, 32'h1000, u[0], 1'b0);
        chk(32'(inst_fault), 32'(!itab[p][u]));
      end
    end
    // Both strobes: only the fetch may happen, the region stays as stored
    core.en(1'b0);
    core.ctl(1'b0, {26'h0, 5'h1, 1'b1});
    core.ctl(1'b1, {1'b0, MASK_64B, 1'b1, 3'h1, 2'h3});
    chk(acc_rdata, {1'b0, 25'h1ffff80, 1'b0, 3'h6, 2'h0});
    end_of_test();
  end
endmodule // tb_region_protection_access_regs

bind region_protection_access_regs region_prot_chk u_chk (.clk, .srst,
  .base_wr, .base_wdata, .acc_wr, .acc_wdata, .base_rdata, .acc_rdata,
  .unit_enable, .unit_active, .inst_valid, .inst_fault, .data_valid,
  .data_fault);
